// File: core/bcd_pkg.sv
// How it works
// - Bit test sets code 010 or 000
// - Bit clear copies source, index modulo 32
// - Compare sets 100 less, 010 equal, 001 greater
// - Compare-decrement stores second operand minus one
// - Signed decrement never flags overflow
// - Compare-branch branches when code AND mask nonzero
// - Branch mask comes from opcode bits 0-2
// - Taken adds 4 plus four times displacement
// - Divide second by first, quotient only
// - Zero divisor raises zero-divide fault
// - Signed divide overflow faults unless masked
// - Masked overflow sets sticky flag, stores low word
// - Extended dividend is even/odd register pair
// - Remainder to even register, quotient next
// - Extended overflow raises no fault
// - Compare-branch signals instruction trace, and branch trace only when taken
// - Indirect call signals instruction and call trace
// - Special register outside supervisor is type fault, except for indirect call
// - Execution from data RAM is unimplemented fault
// - Indirect call operand and opcode faults
`default_nettype none
package bcd_pkg;
  localparam int WORD_W = 32;
  localparam int CC_W = 3;
  localparam int MASK_LSB = 0;
  localparam int DIV_STEPS = 64;
  localparam logic [2:0] CC_NONE = 3'h0;
  localparam logic [2:0] CC_GREATER = 3'h1;
  localparam logic [2:0] CC_EQUAL = 3'h2;
  localparam logic [2:0] CC_LESS = 3'h4;
  localparam logic [31:0] IP_STEP = 32'h4;
  localparam logic [31:0] RESET_WORD = 32'h0;
  typedef enum logic [3:0] {
    OP_CHKBIT, OP_CLRBIT, OP_CMPDECI, OP_CMPDECO, OP_CMPIB, OP_CMPOB,
    OP_DIVI, OP_DIVO, OP_EDIV, OP_CALLX
  } bcd_op_type;
endpackage : bcd_pkg
`default_nettype wire

// File: core/bcd_compare.sv
`default_nettype none
// Three-way comparator, signed or unsigned
module bcd_compare
  import bcd_pkg::*;
(
  input wire logic [31:0] first,
  input wire logic [31:0] second,
  input wire logic isSigned,
  output logic [2:0] code
);
  logic lessU;
  logic lessS;
  logic lessSel;
  assign lessU = first < second;
  assign lessS = $signed(first) < $signed(second);
  assign lessSel = isSigned ? lessS : lessU;
  // Less wins, then equal, else greater
  assign code = lessSel ? CC_LESS :
                (first == second) ? CC_EQUAL : CC_GREATER;
endmodule : bcd_compare
`default_nettype wire

// File: core/bcd_divider.sv
`default_nettype none
// Restoring divider, one quotient bit per clock, 64 by 32 unsigned
module bcd_divider
  import bcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [63:0] dividend,
  input wire logic [31:0] divisor,
  output logic busy,
  output logic done,
  output logic [63:0] quotient,
  output logic [32:0] remainder
);
  logic [6:0] count_q;
  logic [63:0] quot_q;
  logic [32:0] rem_q;
  logic [31:0] dvs_q;
  logic busy_q;
  logic done_q;
  logic [32:0] shifted;
  logic fits;
  assign shifted = {rem_q[31:0], quot_q[63]};
  assign fits = shifted >= {1'b0, dvs_q};
  // Long width keeps extended overflow harmless
  always_ff @(posedge clk) begin
    done_q <= 1'b0;
    if (rst) begin
      count_q <= 7'h00;
      busy_q <= 1'b0;
      quot_q <= 64'h0;
      rem_q <= 33'h0;
      dvs_q <= 32'h0;
    end else if (start && !busy_q) begin
      quot_q <= dividend;
      rem_q <= 33'h0;
      dvs_q <= divisor;
      count_q <= 7'(DIV_STEPS);
      busy_q <= 1'b1;
    end else if (busy_q) begin
      rem_q <= fits ? shifted - {1'b0, dvs_q} : shifted;
      quot_q <= {quot_q[62:0], fits};
      count_q <= count_q - 7'h01;
      if (count_q == 7'h01) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
  assign busy = busy_q;
  assign done = done_q;
  assign quotient = quot_q;
  assign remainder = rem_q;
endmodule : bcd_divider
`default_nettype wire

// File: core/bcd_datapath.sv
`default_nettype none
// Execution datapath for bit, compare, branch and divide instructions
module bcd_datapath
  import bcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic issueValid,
  input wire logic [3:0] issueOp,
  input wire logic [2:0] opcodeLow,
  input wire logic [31:0] srcFirst,
  input wire logic [31:0] srcSecond,
  input wire logic [31:0] srcSecondHigh,
  input wire logic [31:0] instrPointer,
  input wire logic [31:0] displacement,
  input wire logic usesSfr,
  input wire logic supervisorMode,
  input wire logic fetchedFromDataRam,
  input wire logic operandValueBad,
  input wire logic operandEncodingBad,
  input wire logic overflow_mask_bit,
  input wire logic trace_enable_bit,
  input wire logic instruction_trace_mode,
  input wire logic branch_trace_mode,
  input wire logic call_trace_mode,
  input wire logic stickyClear,
  output logic busy,
  output logic done,
  output logic [2:0] condition_code_field,
  output logic ccWrite,
  output logic dstWrite,
  output logic [31:0] dstValue,
  output logic dstPairWrite,
  output logic [31:0] dstPairValue,
  output logic ipWrite,
  output logic [31:0] ipNext,
  output logic branchTaken,
  output logic sticky_int_overflow_flag,
  output logic faultZeroDivide,
  output logic faultIntOverflow,
  output logic faultTypeMismatch,
  output logic faultUnimplemented,
  output logic faultOperand,
  output logic faultOpcode,
  output logic instrTraceEvent,
  output logic branchTraceEvent,
  output logic callTraceEvent,
  output logic traceFault
);
  typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_FINISH} bcd_state_type;

  bcd_state_type state_q;
  bcd_op_type op_q;
  logic [31:0] first_q;
  logic [31:0] second_q;
  logic busy_q;
  logic done_q;
  logic [2:0] cc_q;
  logic ccWrite_q;
  logic dstWrite_q;
  logic [31:0] dst_q;
  logic pairWrite_q;
  logic [31:0] pair_q;
  logic ipWrite_q;
  logic [31:0] ipNext_q;
  logic taken_q;
  logic sticky_q;
  logic fZero_q;
  logic fOvf_q;
  logic fType_q;
  logic fUnimp_q;
  logic fOperand_q;
  logic fOpcode_q;
  logic trI_q;
  logic trB_q;
  logic trC_q;
  logic trFault_q;

  // Decoding of the issued instruction
  bcd_op_type issueKind;
  logic isDivide;
  logic preFault;
  logic typeBad;
  logic opBadValue;
  logic opBadEnc;
  assign issueKind = bcd_op_type'(issueOp);
  assign isDivide = issueKind inside {OP_DIVI, OP_DIVO, OP_EDIV};
  // The indirect call has no special-register type check
  assign typeBad = usesSfr && !supervisorMode &&
                   issueKind != OP_CALLX;
  assign opBadValue = issueKind == OP_CALLX && operandValueBad;
  assign opBadEnc = issueKind == OP_CALLX && operandEncodingBad;
  // Faults found at issue stop the instruction before any result
  assign preFault = fetchedFromDataRam || typeBad || opBadValue || opBadEnc;

  // Bit operations, index always modulo 32
  logic [4:0] bitIdx;
  logic bitSet;
  logic [31:0] clearedWord;
  assign bitIdx = srcFirst[4:0];
  assign bitSet = srcSecond[bitIdx];
  assign clearedWord = srcSecond & ~(32'h1 << bitIdx);

  // Three-way comparison shared by compare-decrement and compare-branch
  logic cmpSigned;
  logic [2:0] cmpCode;
  assign cmpSigned = issueKind inside {OP_CMPDECI, OP_CMPIB};
  bcd_compare u_compare (
    .first(srcFirst),
    .second(srcSecond),
    .isSigned(cmpSigned),
    .code(cmpCode)
  );

  // Branch target arithmetic, displacement counted in words
  logic branchHit;
  logic [31:0] ipSeq;
  logic [31:0] ipTarget;
  assign branchHit = (cmpCode & opcodeLow) != CC_NONE;
  assign ipSeq = instrPointer + IP_STEP;
  assign ipTarget = ipSeq + {displacement[29:0], 2'b00};

  // Decrement wraps silently; no overflow path exists for it
  logic [31:0] decremented;
  assign decremented = srcSecond - 32'h1;

  // Divide operands; signed forms divide magnitudes
  logic divSignedIss;
  logic [31:0] magSecond;
  logic [31:0] magFirst;
  logic [63:0] divDividend;
  logic [31:0] divDivisor;
  assign divSignedIss = issueKind == OP_DIVI;
  assign magSecond = (divSignedIss && srcSecond[31]) ? -srcSecond : srcSecond;
  assign magFirst = (divSignedIss && srcFirst[31]) ? -srcFirst : srcFirst;
  // Extended dividend: low word from even register, high from next
  assign divDividend = (issueKind == OP_EDIV) ?
                       {srcSecondHigh, srcSecond} :
                       {32'h0, magSecond};
  assign divDivisor = magFirst;
  logic divStart;
  logic divDone;
  logic [63:0] divQuot;
  logic [32:0] divRem;
  assign divStart = issueValid && state_q == ST_IDLE && isDivide &&
                    !preFault && srcFirst != 32'h0;
  bcd_divider u_divider (
    .clk(clk),
    .rst(rst),
    .start(divStart),
    .dividend(divDividend),
    .divisor(divDivisor),
    .busy(),
    .done(divDone),
    .quotient(divQuot),
    .remainder(divRem)
  );

  // Signed result fix-up and overflow check
  logic negQuot;
  logic [31:0] signedQuot;
  logic signedOvf;
  assign negQuot = first_q[31] ^ second_q[31];
  assign signedQuot = negQuot ? -divQuot[31:0] : divQuot[31:0];
  // Only most-negative divided by minus one can overflow here
  assign signedOvf = !negQuot && divQuot[31];

  // Trace events for the issued instruction
  logic brTraceEv;
  logic callTraceEv;
  assign brTraceEv = issueKind inside {OP_CMPIB, OP_CMPOB} && branchHit;
  assign callTraceEv = issueKind == OP_CALLX;

  // Issue latch and sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      op_q <= OP_CHKBIT;
      first_q <= RESET_WORD;
      second_q <= RESET_WORD;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (divStart) begin
            state_q <= ST_DIVIDE;
            op_q <= issueKind;
            first_q <= srcFirst;
            second_q <= srcSecond;
          end
        end
        ST_DIVIDE: begin
          if (divDone) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Result, fault and trace outputs; pulses last one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
      cc_q <= CC_NONE;
      ccWrite_q <= 1'b0;
      dstWrite_q <= 1'b0;
      dst_q <= RESET_WORD;
      pairWrite_q <= 1'b0;
      pair_q <= RESET_WORD;
      ipWrite_q <= 1'b0;
      ipNext_q <= RESET_WORD;
      taken_q <= 1'b0;
      fZero_q <= 1'b0;
      fOvf_q <= 1'b0;
      fType_q <= 1'b0;
      fUnimp_q <= 1'b0;
      fOperand_q <= 1'b0;
      fOpcode_q <= 1'b0;
      trI_q <= 1'b0;
      trB_q <= 1'b0;
      trC_q <= 1'b0;
      trFault_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      ccWrite_q <= 1'b0;
      dstWrite_q <= 1'b0;
      pairWrite_q <= 1'b0;
      ipWrite_q <= 1'b0;
      taken_q <= 1'b0;
      fZero_q <= 1'b0;
      fOvf_q <= 1'b0;
      fType_q <= 1'b0;
      fUnimp_q <= 1'b0;
      fOperand_q <= 1'b0;
      fOpcode_q <= 1'b0;
      trI_q <= 1'b0;
      trB_q <= 1'b0;
      trC_q <= 1'b0;
      trFault_q <= 1'b0;
      busy_q <= divStart || (state_q == ST_DIVIDE && !divDone);
      if (issueValid && state_q == ST_IDLE && !divStart) begin
        done_q <= 1'b1;
        if (preFault) begin
          fUnimp_q <= fetchedFromDataRam;
          fType_q <= typeBad;
          fOperand_q <= opBadValue;
          fOpcode_q <= opBadEnc;
        end else if (isDivide) begin
          fZero_q <= 1'b1;
        end else begin
          trI_q <= 1'b1;
          trB_q <= brTraceEv;
          trC_q <= callTraceEv;
          trFault_q <= trace_enable_bit && (instruction_trace_mode ||
                       (brTraceEv && branch_trace_mode) ||
                       (callTraceEv && call_trace_mode));
          case (issueKind)
            OP_CHKBIT: begin
              ccWrite_q <= 1'b1;
              cc_q <= bitSet ? CC_EQUAL : CC_NONE;
            end
            OP_CLRBIT: begin
              dstWrite_q <= 1'b1;
              dst_q <= clearedWord;
            end
            OP_CMPDECI, OP_CMPDECO: begin
              ccWrite_q <= 1'b1;
              cc_q <= cmpCode;
              dstWrite_q <= 1'b1;
              dst_q <= decremented;
            end
            OP_CMPIB, OP_CMPOB: begin
              ccWrite_q <= 1'b1;
              cc_q <= cmpCode;
              ipWrite_q <= 1'b1;
              taken_q <= branchHit;
              ipNext_q <= branchHit ? ipTarget : ipSeq;
            end
            default: begin
            end
          endcase
        end
      end else if (state_q == ST_DIVIDE && divDone) begin
        done_q <= 1'b1;
        trI_q <= 1'b1;
        trFault_q <= trace_enable_bit && instruction_trace_mode;
        case (op_q)
          OP_EDIV: begin
            // Oversized results are written as they fall, no fault
            dstWrite_q <= 1'b1;
            dst_q <= divRem[31:0];
            pairWrite_q <= 1'b1;
            pair_q <= divQuot[31:0];
          end
          OP_DIVI: begin
            if (signedOvf && !overflow_mask_bit) begin
              fOvf_q <= 1'b1;
            end else begin
              dstWrite_q <= 1'b1;
              dst_q <= signedQuot;
            end
          end
          default: begin
            dstWrite_q <= 1'b1;
            dst_q <= divQuot[31:0];
          end
        endcase
      end
    end
  end

  // Sticky overflow flag; a new overflow beats a clear
  logic stickySet;
  assign stickySet = state_q == ST_DIVIDE && divDone && op_q == OP_DIVI &&
                     signedOvf && overflow_mask_bit;
  always_ff @(posedge clk) begin
    if (rst) begin
      sticky_q <= 1'b0;
    end else if (stickySet) begin
      sticky_q <= 1'b1;
    end else if (stickyClear) begin
      sticky_q <= 1'b0;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign condition_code_field = cc_q;
  assign ccWrite = ccWrite_q;
  assign dstWrite = dstWrite_q;
  assign dstValue = dst_q;
  assign dstPairWrite = pairWrite_q;
  assign dstPairValue = pair_q;
  assign ipWrite = ipWrite_q;
  assign ipNext = ipNext_q;
  assign branchTaken = taken_q;
  assign sticky_int_overflow_flag = sticky_q;
  assign faultZeroDivide = fZero_q;
  assign faultIntOverflow = fOvf_q;
  assign faultTypeMismatch = fType_q;
  assign faultUnimplemented = fUnimp_q;
  assign faultOperand = fOperand_q;
  assign faultOpcode = fOpcode_q;
  assign instrTraceEvent = trI_q;
  assign branchTraceEvent = trB_q;
  assign callTraceEvent = trC_q;
  assign traceFault = trFault_q;
endmodule : bcd_datapath
`default_nettype wire

// File: tb/bcd_rf_model.sv
`default_nettype none
// Far-side register file: keeps the last value of each kind and
// which writes the latest completion carried, so stale data shows
module bcd_rf_model
  import bcd_pkg::*;
(
  input wire logic clk,
  input wire logic done,
  input wire logic dstWrite,
  input wire logic [31:0] dstValue,
  input wire logic dstPairWrite,
  input wire logic [31:0] dstPairValue,
  input wire logic ccWrite,
  input wire logic [2:0] condition_code_field,
  input wire logic ipWrite,
  input wire logic [31:0] ipNext,
  output logic [31:0] rfDst_q,
  output logic [31:0] rfPair_q,
  output logic [2:0] rfCc_q,
  output logic [31:0] rfIp_q,
  output logic [3:0] rfWr_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // Even register takes the remainder, the odd one the quotient
  always_ff @(posedge clk) begin
    if (dstWrite) rfDst_q <= dstValue;
    if (dstPairWrite) rfPair_q <= dstPairValue;
    if (ccWrite) rfCc_q <= condition_code_field;
    if (ipWrite) rfIp_q <= ipNext;
    if (done) rfWr_q <= {dstWrite, dstPairWrite, ccWrite, ipWrite};
  end
endmodule // bcd_rf_model
`default_nettype wire

// File: tb/bcd_datapath_sva.sv
`default_nettype none
// Boundary checks on the datapath; sees only its ports
module bcd_datapath_sva
  import bcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic issueValid,
  input wire logic [3:0] issueOp,
  input wire logic [2:0] opcodeLow,
  input wire logic [31:0] srcFirst,
  input wire logic [31:0] srcSecond,
  input wire logic [31:0] instrPointer,
  input wire logic [31:0] displacement,
  input wire logic usesSfr,
  input wire logic supervisorMode,
  input wire logic fetchedFromDataRam,
  input wire logic busy,
  input wire logic done,
  input wire logic [2:0] condition_code_field,
  input wire logic ccWrite,
  input wire logic dstWrite,
  input wire logic [31:0] dstValue,
  input wire logic ipWrite,
  input wire logic [31:0] ipNext,
  input wire logic branchTaken,
  input wire logic faultZeroDivide,
  input wire logic faultIntOverflow,
  input wire logic faultTypeMismatch,
  input wire logic faultUnimplemented
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Reference values at the taking edge; past() of these ties each
  // result to the operands offered, not to whatever follows
  wire logic take = issueValid && !busy;
  wire logic bad = fetchedFromDataRam || (usesSfr && !supervisorMode);
  wire logic ok = take && !bad;
  wire logic sgn = issueOp == OP_CMPDECI || issueOp == OP_CMPIB;
  wire logic lt = sgn ? $signed(srcFirst) < $signed(srcSecond)
    : srcFirst < srcSecond;
  wire logic [2:0] cmp = lt ? CC_LESS
    : srcFirst == srcSecond ? CC_EQUAL : CC_GREATER;
  wire logic bitSel = srcSecond[srcFirst[4:0]];
  wire logic [31:0] clrV = srcSecond & ~(32'h1 << srcFirst[4:0]);
  wire logic [31:0] decV = srcSecond - 32'h1;
  wire logic [31:0] ipSeq = instrPointer + IP_STEP;
  wire logic [31:0] ipTk = ipSeq + (displacement << 2);
  wire logic isDec = issueOp == OP_CMPDECI || issueOp == OP_CMPDECO;
  wire logic isBr = issueOp == OP_CMPIB || issueOp == OP_CMPOB;
  wire logic isDiv = issueOp inside {OP_DIVI, OP_DIVO, OP_EDIV};
  wire logic isLong = issueOp == OP_DIVO || issueOp == OP_EDIV;
  property p_chk;
    ok && issueOp == OP_CHKBIT |=> ccWrite &&
      condition_code_field == ($past(bitSel) ? CC_EQUAL : CC_NONE);
  endproperty
  a_chk: assert property (p_chk) else $error("bit test code");
  property p_clr;
    ok && issueOp == OP_CLRBIT |=> dstWrite && dstValue == $past(clrV);
  endproperty
  a_clr: assert property (p_clr) else $error("bit clear value");
  property p_dec;
    ok && isDec |=> dstWrite && dstValue == $past(decV) &&
      condition_code_field == $past(cmp) && !faultIntOverflow;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement");
  property p_ip;
    ok && isBr |=> ipWrite &&
      ipNext == (branchTaken ? $past(ipTk) : $past(ipSeq));
  endproperty
  a_ip: assert property (p_ip) else $error("next pointer");
  property p_mask;
    ipWrite |-> branchTaken == |(condition_code_field & $past(opcodeLow));
  endproperty
  a_mask: assert property (p_mask) else $error("branch mask");
  property p_ram;
    take && fetchedFromDataRam |=> done && faultUnimplemented && !dstWrite;
  endproperty
  a_ram: assert property (p_ram) else $error("data ram fetch");
  property p_type;
    take && usesSfr && !supervisorMode && issueOp != OP_CALLX
      |=> done && faultTypeMismatch && !ccWrite;
  endproperty
  a_type: assert property (p_type) else $error("special reg");
  property p_zero;
    ok && isDiv && srcFirst == 32'h0 |=> done && faultZeroDivide && !dstWrite;
  endproperty
  a_zero: assert property (p_zero) else $error("zero divisor");
  property p_len;
    ok && isLong && srcFirst != 32'h0
      |=> busy [*8] ##57 busy ##1 done && dstWrite;
  endproperty
  a_len: assert property (p_len) else $error("divide length");
  // Main scenarios reached
  c_br: cover property (ipWrite && branchTaken);
  c_ovf: cover property (done && faultIntOverflow);
  c_zero: cover property (done && faultZeroDivide);
endmodule // bcd_datapath_sva
bind bcd_datapath bcd_datapath_sva u_sva (.*);
`default_nettype wire

// File: tb/bit_compare_divide_datapath_test.sv
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
  err_total++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
// Self-checking bench against a reference model built from integers
module bit_compare_divide_datapath_test
  import bcd_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  int err_total = 0;
  int cmp_count = 0;
  logic clk, rst, issueValid, usesSfr, supervisorMode, fetchedFromDataRam;
  logic operandValueBad, operandEncodingBad, overflow_mask_bit, stickyClear;
  logic trace_enable_bit, instruction_trace_mode, branch_trace_mode;
  logic call_trace_mode;
  logic [3:0] issueOp;
  logic [2:0] opcodeLow;
  logic [31:0] srcFirst, srcSecond, srcSecondHigh, instrPointer, displacement;
  wire logic busy, done, ccWrite, dstWrite, dstPairWrite, ipWrite;
  wire logic branchTaken, sticky_int_overflow_flag, faultZeroDivide;
  wire logic faultIntOverflow, faultTypeMismatch, faultUnimplemented;
  wire logic faultOperand, faultOpcode, instrTraceEvent, branchTraceEvent;
  wire logic callTraceEvent, traceFault;
  wire logic [2:0] condition_code_field, rfCc_q;
  wire logic [31:0] dstValue, dstPairValue, ipNext, rfDst_q, rfPair_q, rfIp_q;
  wire logic [3:0] rfWr_q;
  wire logic [5:0] flt = {faultZeroDivide, faultIntOverflow,
    faultTypeMismatch, faultUnimplemented, faultOperand, faultOpcode};
  wire logic [3:0] trc = {instrTraceEvent, branchTraceEvent,
    callTraceEvent, traceFault};
  logic [31:0] seed = 32'h30;
  logic [31:0] eDst, ePair, eIp;
  logic [2:0] eCc;
  logic [3:0] eWr, eTr;
  logic [5:0] eFlt;
  logic eSticky = 1'b0;
  bcd_datapath DUT (.*);
  bcd_rf_model u_rf (.*);
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog far beyond the few thousand cycles the run needs
  initial begin
    #(60000 * 100);
    err_total++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference outcome of the instruction about to be offered
  task automatic model();
    longint a, b, q;
    logic [63:0] dv;
    logic [2:0] cc;
    logic sgn, tk, cx, ovf;
    sgn = issueOp inside {OP_CMPDECI, OP_CMPIB, OP_DIVI};
    a = sgn ? longint'($signed(srcFirst)) : longint'(srcFirst);
    b = sgn ? longint'($signed(srcSecond)) : longint'(srcSecond);
    cc = a < b ? CC_LESS : a == b ? CC_EQUAL : CC_GREATER;
    cx = issueOp == OP_CALLX;
    tk = |(cc & opcodeLow);
    eCc = issueOp == OP_CHKBIT ? (srcSecond[srcFirst[4:0]] ? CC_EQUAL
      : CC_NONE) : cc;
    eDst = issueOp == OP_CLRBIT ? srcSecond & ~(32'h1 << srcFirst[4:0])
      : srcSecond - 32'h1;
    eIp = instrPointer + 32'h4 + (tk ? displacement << 2 : 32'h0);
    eFlt = {2'b0, !cx && usesSfr && !supervisorMode, fetchedFromDataRam,
      cx && operandValueBad, cx && operandEncodingBad};
    eWr = 4'h0;
    if (eFlt == 6'h0) begin
      case (issueOp)
        OP_CHKBIT: eWr = 4'h2;
        OP_CLRBIT: eWr = 4'h8;
        OP_CMPDECI, OP_CMPDECO: eWr = 4'hA;
        OP_CMPIB, OP_CMPOB: eWr = 4'h3;
        OP_CALLX: eWr = 4'h0;
        default: begin
          q = a == 0 ? 0 : b / a;
          ovf = sgn && q == 64'sd2147483648;
          dv = {srcSecondHigh, srcSecond};
          if (a == 0) eFlt[5] = 1'b1;
          else if (ovf && !overflow_mask_bit) eFlt[4] = 1'b1;
          else if (issueOp != OP_EDIV) eWr = 4'h8;
          else eWr = 4'hC;
          eSticky |= ovf && overflow_mask_bit;
          eDst = issueOp == OP_EDIV ? 32'(dv % srcFirst) : q[31:0];
          ePair = 32'(dv / srcFirst);
        end
      endcase
    end
    eTr = 4'h0;
    if (eFlt == 6'h0) begin
      eTr[3:1] = {1'b1, eWr[0] && tk, cx};
      eTr[0] = trace_enable_bit && (instruction_trace_mode ||
        (eTr[2] && branch_trace_mode) || (cx && call_trace_mode));
    end
  endtask
  // Offer one instruction, wait for completion, compare every result
  task automatic run_op(input logic [3:0] op);
    int n;
    issueOp = op;
    model();
    issueValid = 1'b1;
    @(posedge clk);
    #1;
    issueValid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 80) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("done", 1'b1, done)
    `CHK("faults", eFlt, flt)
    if (eFlt[4] !== 1'b1) `CHK("trace", eTr, trc)
    @(posedge clk);
    #1;
    `CHK("sticky", eSticky, sticky_int_overflow_flag)
    `CHK("writes", eWr, rfWr_q)
    if (eWr[3]) `CHK("dst", eDst, rfDst_q)
    if (eWr[2]) `CHK("pair", ePair, rfPair_q)
    if (eWr[1]) `CHK("cc", eCc, rfCc_q)
    if (eWr[0]) `CHK("ip", eIp, rfIp_q)
  endtask
  // Random operands and controls; issue faults about one time in eight
  task automatic set_rand();
    logic [31:0] r;
    r = rnd();
    {trace_enable_bit, instruction_trace_mode, branch_trace_mode} = r[2:0];
    {call_trace_mode, overflow_mask_bit, supervisorMode} = r[5:3];
    usesSfr = r[10:8] == 3'h0;
    fetchedFromDataRam = r[14:11] == 4'h0;
    operandValueBad = r[18:16] == 3'h0;
    operandEncodingBad = r[22:20] == 3'h0;
    opcodeLow = r[26:24];
    srcFirst = r[28] ? rnd() : rnd() % 40;
    srcSecond = r[29] ? rnd() : rnd() % 40;
    srcSecondHigh = srcFirst == 0 ? 32'h0 : rnd() % srcFirst;
    instrPointer = rnd();
    displacement = rnd();
  endtask
  initial begin
    {rst, issueValid, stickyClear} = 3'b100;
    issueOp = 4'h0;
    set_rand();
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("reset", 3'h0, {busy, done, sticky_int_overflow_flag})
    repeat (150) begin
      set_rand();
      run_op(4'(rnd() % 10));
    end
    $display("test random mix done");
    // Every mask against less, equal, greater, and a pair whose order
    // flips between the signed and the unsigned reading
    {usesSfr, fetchedFromDataRam} = 2'b00;
    for (int m = 0; m < 16; m++) begin
      for (int p = 0; p < 4; p++) begin
        opcodeLow = 3'(m);
        srcFirst = p == 3 ? 32'hFFFFFFFF : 32'(p);
        srcSecond = 32'h1;
        run_op(m[3] ? OP_CMPOB : OP_CMPIB);
      end
    end
    $display("test branch masks done");
    // Overflowing divide unmasked then masked, then a wrapping decrement
    srcFirst = 32'hFFFFFFFF;
    srcSecond = 32'h80000000;
    for (int k = 0; k < 2; k++) begin
      overflow_mask_bit = k[0];
      run_op(OP_DIVI);
    end
    run_op(OP_CMPDECI);
    stickyClear = 1'b1;
    @(posedge clk);
    #1;
    stickyClear = 1'b0;
    eSticky = 1'b0;
    `CHK("sticky clear", 1'b0, sticky_int_overflow_flag)
    $display("test overflow done");
    // Zero divisor on each divide, then call faults and call trace
    srcFirst = 32'h0;
    for (int k = 0; k < 3; k++) run_op(4'(OP_DIVI + k));
    {trace_enable_bit, instruction_trace_mode, call_trace_mode} = 3'b101;
    for (int k = 0; k < 4; k++) begin
      {operandValueBad, operandEncodingBad} = 2'(k);
      run_op(OP_CALLX);
    end
    $display("test faults done");
    finish_test();
  end
endmodule // bit_compare_divide_datapath_test
`default_nettype wire
